// file: core/ucrb_core.v
// Behaviour
// - Baud down-counter reloads at zero and on every low divisor byte write.
// - One baud tick per zero, rate equals clock over divisor plus one.
// - Transmit bit clock divides baud ticks by 16, 8 or 2.
// - Async receiver steps 16 or 8 sample states per bit on baud ticks; sync shifts one bit per sample edge.
// - Four clock modes; sync select picks asynchronous or synchronous.
// - In sync mode, clock direction picks internal generator or external clock.
// - Transfer clock pin used only in synchronous mode.
// - Divisor is twelve bits from high and low divisor registers.
// - Double speed halves divider and receiver samples to eight.
// - External clock passes synchroniser then edge detector, two cycles delay.
// - Sync receive samples on the edge opposite the transmit change edge.
// - Receive buffer is two-entry circular FIFO; each data read advances it unless it is empty.
// - Framing, overrun and ninth bit stored per entry; read status first.
// - With FIFO full, shift register holds a third character until next start.
// - One transmit buffer ahead of shift register gives back-to-back frames.
// - Receiver detects framing, overrun and parity errors.
// - Three interrupt requests: transmit complete, data empty, receive complete.
// - Frames of 5 to 9 data bits, 1 or 2 stops, odd or even parity.
// - Polarity clear: change on rising, sample on falling; set swaps edges.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ucrb_map.vh"
module ucrb_core #(
    parameter DIV_W = 12
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // Serial pins
    input wire rxd_in,
    output reg txd_out_ff,
    input wire xck_in,
    output reg xck_out_ff,
    output reg xck_oe_ff,
    // Interrupt requests
    output reg irq_rx_done_ff,
    output reg irq_tx_done_ff,
    output reg irq_tx_empty_ff
);
    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] stat_a_ff;
    reg [7:0] ctrl_b_ff;
    reg [7:0] ctrl_c_ff;
    reg xfer_clock_direction_ff;
    reg [3:0] baud_divisor_high_ff;
    reg [DIV_W-1:0] baud_divisor_ff;
    reg [DIV_W-1:0] cnt_ff;
    reg baud_tick_ff;
    reg [3:0] txpre_ff;
    reg xsync1_ff, xsync2_ff, xprev_ff;
    reg xck_int_ff;
    wire wr_data = reg_wr && reg_addr == `UCRB_ADDR_DATA;
    wire wr_low = reg_wr && reg_addr == `UCRB_ADDR_DIV_LOW;
    wire rd_data = reg_rd && reg_addr == `UCRB_ADDR_DATA;
    wire sync_mode_select = ctrl_c_ff[`UCRB_C_MSEL];
    wire double_speed_select = stat_a_ff[`UCRB_A_U2X];
    wire clock_polarity_select = ctrl_c_ff[`UCRB_C_POL];
    wire slave_mode = sync_mode_select && !xfer_clock_direction_ff;
    wire master_mode = sync_mode_select && xfer_clock_direction_ff;
    wire [3:0] char_size = {ctrl_b_ff[`UCRB_B_SZ2], ctrl_c_ff[`UCRB_C_SZ1],
        ctrl_c_ff[`UCRB_C_SZ0]} == 3'h7 ? 4'h9 :
        {2'h0, ctrl_c_ff[`UCRB_C_SZ1], ctrl_c_ff[`UCRB_C_SZ0]} + 4'h5;
    // Samples per bit; sync uses 2, double speed 8, else 16
    wire [4:0] spb = sync_mode_select ? `UCRB_DIV_SYNC :
        (double_speed_select ? `UCRB_DIV_DOUBLE : `UCRB_DIV_NORMAL);

    function parity_of;
        input [8:0] d;
        input [3:0] n;
        input odd;
        integer i;
        begin
            parity_of = odd;
            for (i = 0; i < 9; i = i + 1) begin
                if (i < n) begin
                    parity_of = parity_of ^ d[i];
                end
            end
        end
    endfunction

    // ****************************************
    // Baud generator
    // ****************************************
    always @(posedge clk) begin
        if (!rst_b) begin
            cnt_ff <= {DIV_W{1'b0}};
            baud_divisor_ff <= {DIV_W{1'b0}};
            baud_tick_ff <= 1'b0;
        end else begin
            baud_tick_ff <= 1'b0;
            if (wr_low) begin
                // High byte is only latched here or at reload
                baud_divisor_ff <= {baud_divisor_high_ff, reg_wdata};
                cnt_ff <= {baud_divisor_high_ff, reg_wdata};
            end else if (cnt_ff == {DIV_W{1'b0}}) begin
                cnt_ff <= {baud_divisor_high_ff, baud_divisor_ff[7:0]};
                baud_divisor_ff <= {baud_divisor_high_ff, baud_divisor_ff[7:0]};
                baud_tick_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end

    // ****************************************
    // Transfer clock: master divider and slave synchroniser
    // ****************************************
    wire xedge_rise = xsync2_ff && !xprev_ff;
    wire xedge_fall = !xsync2_ff && xprev_ff;
    wire mtick = baud_tick_ff && !slave_mode;
    wire [3:0] spb_m1 = spb[3:0] - 4'h1;
    wire pre_wrap = mtick && (txpre_ff == spb_m1);
    // In master mode the internal clock toggles each baud tick
    wire m_rise = master_mode && baud_tick_ff && !xck_int_ff;
    wire m_fall = master_mode && baud_tick_ff && xck_int_ff;
    wire s_rise = slave_mode ? xedge_rise : m_rise;
    wire s_fall = slave_mode ? xedge_fall : m_fall;
    // Change edge and sample edge are opposite, swapped by polarity
    wire sync_change = clock_polarity_select ? s_fall : s_rise;
    wire sync_sample = clock_polarity_select ? s_rise : s_fall;
    wire tx_bit = sync_mode_select ? sync_change : pre_wrap;
    always @(posedge clk) begin
        if (!rst_b) begin
            xsync1_ff <= 1'b0;
            xsync2_ff <= 1'b0;
            xprev_ff <= 1'b0;
            xck_int_ff <= 1'b0;
            txpre_ff <= 4'h0;
            xck_out_ff <= 1'b0;
            xck_oe_ff <= 1'b0;
        end else begin
            xsync1_ff <= xck_in;
            xsync2_ff <= xsync1_ff;
            xprev_ff <= xsync2_ff;
            if (m_rise || m_fall) begin
                xck_int_ff <= !xck_int_ff;
            end
            if (mtick) begin
                txpre_ff <= pre_wrap ? 4'h0 : txpre_ff + 4'h1;
            end
            xck_out_ff <= master_mode & (xck_int_ff ^ (m_rise | m_fall));
            xck_oe_ff <= master_mode;
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    reg [8:0] tbuf_ff;
    reg tbuf_full_ff;
    reg [11:0] tsh_ff;
    reg [3:0] tleft_ff;
    reg tbusy_ff;
    wire [3:0] nb = char_size;
    wire tpar_en = ctrl_c_ff[`UCRB_C_PM1];
    wire [3:0] tlen = nb + {3'h0, tpar_en} + {3'h0, ctrl_c_ff[`UCRB_C_SBS]} + 4'h1;
    reg [11:0] nxt_frame;
    integer k;
    always @* begin
        nxt_frame = 12'hFFF;
        for (k = 0; k < 9; k = k + 1) begin
            if (k < nb) begin
                nxt_frame[k] = tbuf_ff[k];
            end
        end
        if (tpar_en) begin
            nxt_frame[nb] = parity_of(tbuf_ff, nb, ctrl_c_ff[`UCRB_C_PM0]);
        end
    end
    // Load only on a bit edge, so a buffered character is never dropped
    wire tload = tbuf_full_ff && ctrl_b_ff[`UCRB_B_TXEN] && tx_bit &&
        (!tbusy_ff || tleft_ff == 4'h0);
    always @(posedge clk) begin
        if (!rst_b) begin
            tbuf_ff <= 9'h000;
            tbuf_full_ff <= 1'b0;
            tsh_ff <= 12'hFFF;
            tleft_ff <= 4'h0;
            tbusy_ff <= 1'b0;
            txd_out_ff <= 1'b1;
        end else begin
            if (wr_data) begin
                tbuf_ff <= {ctrl_b_ff[`UCRB_B_TXB8], reg_wdata};
                tbuf_full_ff <= 1'b1;
            end else if (tload) begin
                tbuf_full_ff <= 1'b0;
            end
            if (tload && tx_bit) begin
                txd_out_ff <= 1'b0;
                tsh_ff <= nxt_frame;
                tleft_ff <= tlen;
                tbusy_ff <= 1'b1;
            end else if (tbusy_ff && tx_bit) begin
                if (tleft_ff == 4'h0) begin
                    tbusy_ff <= 1'b0;
                    txd_out_ff <= 1'b1;
                end else begin
                    txd_out_ff <= tsh_ff[0];
                    tsh_ff <= {1'b1, tsh_ff[11:1]};
                    tleft_ff <= tleft_ff - 4'h1;
                end
            end
        end
    end
    wire tx_done = tbusy_ff && tx_bit && tleft_ff == 4'h0 && !tload;

    // ****************************************
    // Receiver with two-entry FIFO plus shift register level
    // ****************************************
    reg [1:0] rst_ff;
    reg [3:0] rph_ff;
    reg [3:0] rcnt_ff;
    reg [10:0] rsh_ff;
    reg hold_ff;
    reg [11:0] rfifo_ff [0:1];
    reg wp_ff, rp_ff;
    reg [1:0] fill_ff;
    reg ovr_pend_ff;
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_BITS = 2'h2;
    wire rtick = sync_mode_select ? sync_sample : baud_tick_ff;
    wire [3:0] half = spb[4:1] - 4'h1;
    wire [3:0] rlen = nb + {3'h0, tpar_en};
    wire fifo_full = fill_ff == 2'h2;
    wire rpop = rd_data && fill_ff != 2'h0;
    wire start_seen = rtick && !rxd_in && ctrl_b_ff[`UCRB_B_RXEN];
    // Held character may move in once an entry frees up
    wire push = hold_ff && !fifo_full;
    // Nine data bits, parity and stop need eleven places; stop lands on top
    wire [10:0] rdat = rsh_ff >> (4'hA - rlen);
    wire rpar_bad = tpar_en && (parity_of(rdat[8:0], nb, ctrl_c_ff[`UCRB_C_PM0]) !=
        rdat[nb]);
    wire [11:0] rentry = {rpar_bad, !rsh_ff[10] ? 1'b1 : 1'b0, ovr_pend_ff,
        rdat[8:0] & ~(9'h1FF << nb)};
    wire [11:0] rhead = rfifo_ff[rp_ff];
    always @(posedge clk) begin
        if (!rst_b) begin
            rst_ff <= RX_IDLE;
            rph_ff <= 4'h0;
            rcnt_ff <= 4'h0;
            rsh_ff <= 11'h000;
            hold_ff <= 1'b0;
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            fill_ff <= 2'h0;
            ovr_pend_ff <= 1'b0;
            rfifo_ff[0] <= 12'h000;
            rfifo_ff[1] <= 12'h000;
        end else begin
            if (push) begin
                rfifo_ff[wp_ff] <= rentry;
                wp_ff <= !wp_ff;
                ovr_pend_ff <= 1'b0;
            end
            if (rpop) begin
                rp_ff <= !rp_ff;
            end
            fill_ff <= fill_ff + {1'b0, push} - {1'b0, rpop};
            case (rst_ff)
                RX_IDLE: begin
                    if (start_seen) begin
                        // New start with a held character and a full FIFO: it is lost
                        if (hold_ff && fifo_full) begin
                            hold_ff <= 1'b0;
                            ovr_pend_ff <= 1'b1;
                        end
                        rph_ff <= 4'h0;
                        rst_ff <= sync_mode_select ? RX_BITS : RX_START;
                        rcnt_ff <= 4'h0;
                    end
                end
                RX_START: begin
                    if (rtick) begin
                        if (rph_ff == half) begin
                            rph_ff <= 4'h0;
                            rst_ff <= rxd_in ? RX_IDLE : RX_BITS;
                        end else begin
                            rph_ff <= rph_ff + 4'h1;
                        end
                    end
                end
                RX_BITS: begin
                    if (rtick) begin
                        if (rph_ff == spb_m1 || sync_mode_select) begin
                            rph_ff <= 4'h0;
                            rsh_ff <= {rxd_in, rsh_ff[10:1]};
                            if (rcnt_ff == rlen) begin
                                rst_ff <= RX_IDLE;
                                hold_ff <= 1'b1;
                            end
                            rcnt_ff <= rcnt_ff + 4'h1;
                        end else begin
                            rph_ff <= rph_ff + 4'h1;
                        end
                    end
                end
                default: begin
                    rst_ff <= RX_IDLE;
                end
            endcase
            if (push && !(rst_ff == RX_BITS && rtick && rcnt_ff == rlen)) begin
                hold_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Register port and interrupts
    // ****************************************
    reg txc_ff;
    always @(posedge clk) begin
        if (!rst_b) begin
            stat_a_ff <= `UCRB_RST_STAT_A;
            ctrl_b_ff <= `UCRB_RST_CTRL_B;
            ctrl_c_ff <= `UCRB_RST_CTRL_C;
            xfer_clock_direction_ff <= 1'b0;
            baud_divisor_high_ff <= 4'h0;
            txc_ff <= 1'b0;
            reg_rdata_ff <= 8'h00;
            irq_rx_done_ff <= 1'b0;
            irq_tx_done_ff <= 1'b0;
            irq_tx_empty_ff <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `UCRB_ADDR_STAT_A) begin
                stat_a_ff[`UCRB_A_U2X] <= reg_wdata[`UCRB_A_U2X];
            end
            if (reg_wr && reg_addr == `UCRB_ADDR_CTRL_B) begin
                ctrl_b_ff[7:2] <= reg_wdata[7:2];
                ctrl_b_ff[`UCRB_B_TXB8] <= reg_wdata[`UCRB_B_TXB8];
            end
            if (reg_wr && reg_addr == `UCRB_ADDR_CTRL_C) begin
                ctrl_c_ff <= {1'b0, reg_wdata[6:0]};
                xfer_clock_direction_ff <= reg_wdata[`UCRB_C_XDIR];
            end
            if (reg_wr && reg_addr == `UCRB_ADDR_DIV_HIGH) begin
                baud_divisor_high_ff <= reg_wdata[3:0];
            end
            // Set beats a write-one clear in the same cycle
            if (tx_done) begin
                txc_ff <= 1'b1;
            end else if (reg_wr && reg_addr == `UCRB_ADDR_STAT_A &&
                reg_wdata[`UCRB_A_TXC]) begin
                txc_ff <= 1'b0;
            end
            ctrl_b_ff[`UCRB_B_RECEIVE_NINTH_BIT] <= rhead[8];
            reg_rdata_ff <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `UCRB_ADDR_DATA: reg_rdata_ff <= rhead[7:0];
                    `UCRB_ADDR_STAT_A: reg_rdata_ff <= {fill_ff != 2'h0, txc_ff,
                        !tbuf_full_ff, rhead[10], rhead[9], rhead[11],
                        double_speed_select, 1'b0};
                    `UCRB_ADDR_CTRL_B: reg_rdata_ff <= {ctrl_b_ff[7:2], rhead[8],
                        ctrl_b_ff[0]};
                    `UCRB_ADDR_CTRL_C: reg_rdata_ff <= {xfer_clock_direction_ff,
                        ctrl_c_ff[6:0]};
                    `UCRB_ADDR_DIV_LOW: reg_rdata_ff <= baud_divisor_ff[7:0];
                    `UCRB_ADDR_DIV_HIGH: reg_rdata_ff <= {4'h0, baud_divisor_high_ff};
                    default: reg_rdata_ff <= 8'h00;
                endcase
            end
            irq_rx_done_ff <= ctrl_b_ff[`UCRB_B_RXCIE] && fill_ff != 2'h0;
            irq_tx_done_ff <= ctrl_b_ff[`UCRB_B_TXCIE] && txc_ff;
            irq_tx_empty_ff <= ctrl_b_ff[`UCRB_B_DREIE] && !tbuf_full_ff;
        end
    end
endmodule // ucrb_core
`default_nettype wire

// file: core/ucrb_map.vh
`ifndef UCRB_MAP_VH
`define UCRB_MAP_VH
// ****************************************
// Register offsets (byte index on the plain port)
// ****************************************
`define UCRB_ADDR_DATA 3'h0
`define UCRB_ADDR_STAT_A 3'h1
`define UCRB_ADDR_CTRL_B 3'h2
`define UCRB_ADDR_CTRL_C 3'h3
`define UCRB_ADDR_DIV_LOW 3'h4
`define UCRB_ADDR_DIV_HIGH 3'h5
// ****************************************
// Field positions
// ****************************************
`define UCRB_A_RXC 7
`define UCRB_A_TXC 6
`define UCRB_A_DRE 5
`define UCRB_A_FE 4
`define UCRB_A_DOR 3
`define UCRB_A_PE 2
`define UCRB_A_U2X 1
`define UCRB_B_RXCIE 7
`define UCRB_B_TXCIE 6
`define UCRB_B_DREIE 5
`define UCRB_B_RXEN 4
`define UCRB_B_TXEN 3
`define UCRB_B_SZ2 2
`define UCRB_B_RECEIVE_NINTH_BIT 1
`define UCRB_B_TXB8 0
`define UCRB_C_MSEL 6
`define UCRB_C_PM1 5
`define UCRB_C_PM0 4
`define UCRB_C_SBS 3
`define UCRB_C_SZ1 2
`define UCRB_C_SZ0 1
`define UCRB_C_POL 0
`define UCRB_C_XDIR 7
// ****************************************
// Reset values and counts
// ****************************************
`define UCRB_RST_STAT_A 8'h20
`define UCRB_RST_CTRL_B 8'h00
`define UCRB_RST_CTRL_C 8'h06
`define UCRB_DIV_NORMAL 5'h10
`define UCRB_DIV_DOUBLE 5'h08
`define UCRB_DIV_SYNC 5'h02
`endif

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ucrb_map.vh"
module tb;
    logic clk, rst_b, reg_wr, reg_rd, txd, xck_o, xck_oe, irq_rx, irq_txc, irq_dre;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    wire rxd_in, xck_in;
    int bad_count, n_compared;

    initial clk = 1'b0;
    always #5 clk = ~clk;

    ucrb_core u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata), .rxd_in(rxd_in),
        .txd_out_ff(txd), .xck_in(xck_in), .xck_out_ff(xck_o), .xck_oe_ff(xck_oe),
        .irq_rx_done_ff(irq_rx), .irq_tx_done_ff(irq_txc), .irq_tx_empty_ff(irq_dre));
    ucrb_peer u_peer (.clk(clk), .txd(txd), .rxd(rxd_in), .transfer_clock_pin(xck_in));

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        check(what, exp, v);
    endtask
    // Polls status A bit b; a bounded poll, not a fixed delay
    task automatic wait_stat(input int b);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 50 && !v[b]; i++) rd(`UCRB_ADDR_STAT_A, v);
    endtask
    task automatic wait_rx;
        wait_stat(`UCRB_A_RXC);
    endtask
    task automatic print_verdict;
        $display("Compared %0d, errors %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        print_verdict;
    end

    initial begin
        logic [7:0] v, b0, b1;
        time t0, t1;
        int n, k, t;
        logic pv;
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        bad_count = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rdc(`UCRB_ADDR_STAT_A, `UCRB_RST_STAT_A, "status a");
        rdc(`UCRB_ADDR_CTRL_B, `UCRB_RST_CTRL_B, "ctrl b");
        rdc(`UCRB_ADDR_CTRL_C, `UCRB_RST_CTRL_C, "ctrl c");
        wr(3'h7, 8'hFF);
        rdc(3'h7, 8'h00, "unmapped");
        // Four clocks per tick, 64 per async bit
        wr(`UCRB_ADDR_DIV_HIGH, 8'h00);
        wr(`UCRB_ADDR_DIV_LOW, 8'h03);
        wr(`UCRB_ADDR_CTRL_B, 8'h98);
        fork
            begin
                u_peer.grab(b0, t0, 64);
                u_peer.grab(b1, t1, 64);
            end
            begin
                wr(`UCRB_ADDR_DATA, 8'h3C);
                wait_stat(`UCRB_A_DRE);
                wr(`UCRB_ADDR_DATA, 8'hC3);
            end
        join
        check("tx byte 0", 8'h3C, b0);
        check("tx byte 1", 8'hC3, b1);
        check("start to start", 16'd640, 16'((t1 - t0) / 10));
        wait_stat(`UCRB_A_TXC);
        rdc(`UCRB_ADDR_STAT_A, 8'h60, "tx status");
        wr(`UCRB_ADDR_CTRL_B, 8'hF8);
        @(posedge clk);
        #1 check("txc irq", 16'h1, irq_txc);
        check("dre irq", 16'h1, irq_dre);
        wr(`UCRB_ADDR_STAT_A, 8'h40);
        rdc(`UCRB_ADDR_STAT_A, 8'h20, "txc clear");
        // Three characters unread: two in the buffer, one held in the shifter
        u_peer.send(8'h11, 64, 1'b0, 1'b1);
        u_peer.send(8'h22, 64, 1'b0, 1'b1);
        u_peer.send(8'h33, 64, 1'b0, 1'b1);
        check("rx irq", 16'h1, irq_rx);
        rdc(`UCRB_ADDR_DATA, 8'h11, "rx 0");
        rdc(`UCRB_ADDR_DATA, 8'h22, "rx 1");
        rdc(`UCRB_ADDR_DATA, 8'h33, "rx 2");
        @(posedge clk);
        #1 check("rx irq clear", 16'h0, irq_rx);
        // Low stop bit
        u_peer.send(8'h5A, 64, 1'b0, 1'b0);
        wait_rx;
        rd(`UCRB_ADDR_STAT_A, v);
        check("frame flag", 8'h10, v & 8'h10);
        rdc(`UCRB_ADDR_DATA, 8'h5A, "rx framed");
        wr(`UCRB_ADDR_STAT_A, 8'h02);
        u_peer.send(8'h96, 32, 1'b0, 1'b1);
        wait_rx;
        rdc(`UCRB_ADDR_DATA, 8'h96, "rx double");
        wr(`UCRB_ADDR_STAT_A, 8'h00);
        // Slave clock at an eighth of the system clock
        wr(`UCRB_ADDR_CTRL_C, 8'h46);
        u_peer.send(8'hE7, 8, 1'b1, 1'b1);
        wait_rx;
        rdc(`UCRB_ADDR_DATA, 8'hE7, "rx slave");
        // High byte is held until the low byte lands or the counter reloads
        wr(`UCRB_ADDR_DIV_HIGH, 8'hF1);
        wr(`UCRB_ADDR_DIV_LOW, 8'h00);
        wr(`UCRB_ADDR_CTRL_C, 8'hC6);
        n = 0;
        k = 0;
        t = 0;
        pv = 1'b0;
        for (int c = 0; c < 3000 && k < 4; c++) begin
            @(posedge clk);
            #1;
            if (xck_o && !pv) begin
                k++;
                if (k == 3) t = c;
                if (k == 4) n = c - t;
            end
            pv = xck_o;
        end
        check("xck period", 16'd514, 16'(n));
        check("xck enable", 16'h1, xck_oe);
        print_verdict;
    end
endmodule // tb
`default_nettype wire

// file: tb/ucrb_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ucrb_monitor (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_ff,
    // Serial pins
    input wire txd_out_ff,
    input wire xck_out_ff,
    input wire xck_oe_ff,
    // Interrupt requests
    input wire irq_rx_done_ff,
    input wire irq_tx_done_ff,
    input wire irq_tx_empty_ff
);
    // ****************************************
    // Shadow registers
    // ****************************************
    logic [7:0] b_ff, c_ff, lo_ff;
    logic [3:0] hi_ff;
    logic [11:0] div_ff;
    logic [12:0] gap_ff;
    logic [1:0] dirty_ff;
    logic xck_q_ff;
    wire tog = xck_out_ff != xck_q_ff;

    // Two toggles must pass after a setting change before the gap is trusted
    always @(posedge clk) begin
        if (!rst_b) begin
            b_ff <= 8'h00;
            c_ff <= 8'h06;
            lo_ff <= 8'h00;
            hi_ff <= 4'h0;
            div_ff <= 12'h000;
            gap_ff <= 13'h0000;
            dirty_ff <= 2'h2;
            xck_q_ff <= 1'b0;
        end else begin
            xck_q_ff <= xck_out_ff;
            gap_ff <= tog ? 13'h0001 : gap_ff + 13'h0001;
            if (reg_wr && reg_addr == 3'h2) b_ff <= reg_wdata;
            if (reg_wr && reg_addr == 3'h3) c_ff <= reg_wdata;
            if (reg_wr && reg_addr == 3'h5) hi_ff <= reg_wdata[3:0];
            if (reg_wr && reg_addr == 3'h4) begin
                lo_ff <= reg_wdata;
                div_ff <= {hi_ff, reg_wdata};
            end else if (tog) begin
                div_ff <= {hi_ff, lo_ff};
            end
            if ((reg_wr && reg_addr >= 3'h3 && reg_addr <= 3'h5) || !xck_oe_ff) begin
                dirty_ff <= 2'h2;
            end else if (tog && dirty_ff != 2'h0) begin
                dirty_ff <= dirty_ff - 2'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    oe_mode_a: assert property (
        $stable(c_ff)[*3] |-> xck_oe_ff == (c_ff[7] & c_ff[6])) else $error("xck enable wrong");
    xck_gap_a: assert property (
        tog && xck_oe_ff && dirty_ff == 2'h0 |-> gap_ff == {1'b0, div_ff} + 13'h0001)
        else $error("xck half period wrong");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 8'h00) else $error("rdata not zero");
    unmapped_zero_a: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    ctrl_c_read_a: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata_ff == c_ff)
        else $error("ctrl c readback wrong");
    ctrl_b_read_a: assert property (reg_rd && reg_addr == 3'h2 |=>
        {reg_rdata_ff[7:2], reg_rdata_ff[0]} == {b_ff[7:2], b_ff[0]}) else $error("ctrl b wrong");
    irq_rx_off_a: assert property ((!b_ff[7])[*2] |-> !irq_rx_done_ff) else $error("rx irq masked");
    irq_txc_off_a: assert property ((!b_ff[6])[*2] |-> !irq_tx_done_ff) else $error("txc irq masked");
    irq_dre_off_a: assert property ((!b_ff[5])[*2] |-> !irq_tx_empty_ff) else $error("dre irq masked");
    reset_state_a: assert property (disable iff (1'b0) !rst_b |=> reg_rdata_ff == 8'h00 &&
        txd_out_ff && !xck_oe_ff && !irq_rx_done_ff) else $error("reset state wrong");

    c_gap: cover property (tog && xck_oe_ff && dirty_ff == 2'h0);
    c_rx_irq: cover property ($rose(irq_rx_done_ff));
    c_read: cover property (reg_rd && reg_addr == 3'h0);
endmodule // ucrb_monitor
bind ucrb_core ucrb_monitor u_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .txd_out_ff(txd_out_ff), .xck_out_ff(xck_out_ff), .xck_oe_ff(xck_oe_ff),
    .irq_rx_done_ff(irq_rx_done_ff), .irq_tx_done_ff(irq_tx_done_ff),
    .irq_tx_empty_ff(irq_tx_empty_ff));
`default_nettype wire

// file: tb/ucrb_peer.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Remote serial device
// ****************************************
module ucrb_peer (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic txd,
    output logic rxd,
    output logic transfer_clock_pin
);
    // Idle line is high, slave clock stands low between frames
    initial begin
        rxd = 1'b1;
        transfer_clock_pin = 1'b0;
    end

    // Start, eight data bits LSB first, one stop; sync frames change data on the rising edge
    task automatic send(input logic [7:0] d, input int per, input logic sy, input logic stp);
        logic [9:0] fr;
        begin
            fr = {stp, d, 1'b0};
            for (int i = 0; i < 10; i++) begin
                rxd <= fr[i];
                transfer_clock_pin <= sy;
                repeat (per / 2) @(posedge clk);
                transfer_clock_pin <= 1'b0;
                repeat (per - per / 2) @(posedge clk);
            end
            rxd <= 1'b1;
            // One idle cycle keeps back-to-back frames from two writes in one step
            @(posedge clk);
        end
    endtask

    // Samples mid-bit; returns at the middle of the stop bit
    task automatic grab(output logic [7:0] d, output time ts, input int per);
        int k;
        begin
            k = 0;
            while (txd !== 1'b0 && k < 4000) begin
                @(posedge clk);
                #1;
                k++;
            end
            ts = $time;
            repeat (per / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (per) @(posedge clk);
                #1 d[i] = txd;
            end
            repeat (per) @(posedge clk);
        end
    endtask
endmodule // ucrb_peer
`default_nettype wire
